// file: psfb_busy_flags.sv
/*
 * Counter and pulse-output busy flag word.
 * Assumes the activity inputs are synchronous levels held by the channel logic.
 */
`timescale 1ns/10ps
`default_nettype none
`include "psfb_consts.svh"

module psfb_busy_flags
    import psfb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // channel activity and variant
    input wire psfb_activity_t act,
    input wire psfb_variant_t variant,
    // flag word
    output logic [15:0] busy_reg
);
    logic [15:0] busy_next;
    logic [15:0] raw;

    genvar i;
    generate
        for (i = 0; i < `PSFB_CTR_CH; i = i + 1)
        begin : g_ctr
            assign raw[`PSFB_CTR_BASE + i] = act.ctr_active[i];
        end
        for (i = 0; i < `PSFB_PLS_CH; i = i + 1)
        begin : g_pls
            assign raw[`PSFB_PLS_BASE + i] = act.pls_active[i];
        end
    endgenerate

    always_comb
    begin
        busy_next = raw;
        if (variant != PSFB_RELAY_OUTPUT)
        begin
            busy_next = busy_next & ~`PSFB_RELAY_CTR_MASK;
        end
        if (variant != PSFB_TRANSISTOR_OUTPUT)
        begin
            busy_next = busy_next & ~`PSFB_TRANS_PLS_MASK;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_reg <= `PSFB_ZERO16;
        end
        else
        begin
            busy_reg <= busy_next;
        end
    end
endmodule
`default_nettype wire

// file: psfb_consts.svh
/*
 * Offsets, field positions and reset values for the status flag bank.
 * Assumes inclusion by bare name from package and modules.
 */
`ifndef PSFB_CONSTS_SVH
`define PSFB_CONSTS_SVH

`define PSFB_ADDR_W 5
`define PSFB_OFF_RUN_STATE 5'h00
`define PSFB_OFF_BUSY_FLAGS 5'h01
`define PSFB_OFF_DIAG_CODE 5'h02
`define PSFB_OFF_IO_BOARD_ERR 5'h04
`define PSFB_OFF_CASSETTE_ERR 5'h08
`define PSFB_OFF_COMM_ERR 5'h0b
`define PSFB_OFF_EXP_VERIFY 5'h0c
`define PSFB_OFF_VARIANT 5'h10
`define PSFB_OFF_INT_STATUS 5'h11
`define PSFB_OFF_INT_MASK 5'h12
`define PSFB_ZERO16 16'h0000
`define PSFB_INT_W 5
`define PSFB_INT_RESET 5'h00
`define PSFB_EV_DIAG 0
`define PSFB_EV_IO_BOARD 1
`define PSFB_EV_CASSETTE 2
`define PSFB_EV_COMM 3
`define PSFB_EV_EXP_VERIFY 4
`define PSFB_CASSETTE_MASK 16'h0006
`define PSFB_EXP_MASK 16'h00ff
`define PSFB_RELAY_CTR_MASK 16'h0f00
`define PSFB_TRANS_PLS_MASK 16'hc000
`define PSFB_CTR_BASE 0
`define PSFB_PLS_BASE 12
`define PSFB_CTR_CH 12
`define PSFB_PLS_CH 4

`endif

// file: psfb_flag_bank.sv
/*
 * Read-only status flag and diagnostic word bank with event interrupt.
 * Assumes status inputs are synchronous to CLOCK and driven by the
 * controller's mode, channel and diagnostic logic.
 */
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "psfb_consts.svh"

module psfb_flag_bank
    import psfb_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // register port
    input wire logic [`PSFB_ADDR_W-1:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // unit modes, one bit per linked unit, high for run
    input wire logic [15:0] UNIT_RUN_MODE,
    // channel activity and build variant
    input wire psfb_activity_t CHANNEL_ACTIVE,
    input wire psfb_variant_t OUTPUT_VARIANT,
    // diagnostic events
    input wire logic DIAG_ERR_STB,
    input wire logic [15:0] DIAG_ERR_CODE,
    input wire logic [15:0] IO_BOARD_ERR_SET,
    input wire logic [15:0] CASSETTE_ERR_SET,
    input wire logic COMM_PORT_IN_USE,
    input wire logic COMM_ERR_STB,
    input wire logic [15:0] COMM_ERR_CONTENT,
    input wire logic [7:0] EXP_PRESENT,
    // interrupt
    output logic IRQ
);
    psfb_status_t st_reg;
    psfb_status_t st_next;
    logic [15:0] busy_word;
    logic [7:0] exp_base_reg;
    logic exp_captured_reg;
    logic [`PSFB_INT_W-1:0] int_status_reg;
    logic [`PSFB_INT_W-1:0] int_status_next;
    logic [`PSFB_INT_W-1:0] int_mask_reg;
    logic [`PSFB_INT_W-1:0] events;
    logic [15:0] rdata_next;
    logic [15:0] exp_changed;

    function automatic logic hit(input logic [`PSFB_ADDR_W-1:0] a,
                                 input logic [`PSFB_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    psfb_busy_flags u_busy (
        .clk(CLOCK),
        .nrst(NRST),
        .act(CHANNEL_ACTIVE),
        .variant(OUTPUT_VARIANT),
        .busy_reg(busy_word)
    );

    // installation baseline is caught on the first clock after reset release
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            exp_base_reg <= 8'h00;
            exp_captured_reg <= 1'b0;
        end
        else if (!exp_captured_reg)
        begin
            exp_base_reg <= EXP_PRESENT;
            exp_captured_reg <= 1'b1;
        end
    end

    assign exp_changed = {8'h00, (EXP_PRESENT ^ exp_base_reg)} & `PSFB_EXP_MASK;

    always_comb
    begin
        st_next = st_reg;
        st_next.run_state = UNIT_RUN_MODE;
        if (DIAG_ERR_STB)
        begin
            st_next.diag_code = DIAG_ERR_CODE;
        end
        st_next.io_board_err = st_reg.io_board_err | IO_BOARD_ERR_SET;
        st_next.cassette_err = st_reg.cassette_err | (CASSETTE_ERR_SET & `PSFB_CASSETTE_MASK);
        if (COMM_PORT_IN_USE && COMM_ERR_STB)
        begin
            st_next.comm_err = COMM_ERR_CONTENT;
        end
        if (exp_captured_reg)
        begin
            st_next.exp_verify = st_reg.exp_verify | exp_changed;
        end
    end

    // status words have no write path at all
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    always_comb
    begin
        events = '0;
        events[`PSFB_EV_DIAG] = DIAG_ERR_STB;
        events[`PSFB_EV_IO_BOARD] = (st_next.io_board_err != st_reg.io_board_err);
        events[`PSFB_EV_CASSETTE] = (st_next.cassette_err != st_reg.cassette_err);
        events[`PSFB_EV_COMM] = COMM_PORT_IN_USE && COMM_ERR_STB;
        events[`PSFB_EV_EXP_VERIFY] = (st_next.exp_verify != st_reg.exp_verify);
    end

    // an event in the clearing cycle survives: set is applied after clear
    always_comb
    begin
        int_status_next = int_status_reg;
        if (WR && hit(ADDR, `PSFB_OFF_INT_STATUS))
        begin
            int_status_next = int_status_next & ~WDATA[`PSFB_INT_W-1:0];
        end
        int_status_next = int_status_next | events;
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            int_status_reg <= `PSFB_INT_RESET;
        end
        else
        begin
            int_status_reg <= int_status_next;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            int_mask_reg <= `PSFB_INT_RESET;
        end
        else if (WR && hit(ADDR, `PSFB_OFF_INT_MASK))
        begin
            int_mask_reg <= WDATA[`PSFB_INT_W-1:0];
        end
    end

    assign IRQ = |(int_status_reg & int_mask_reg);

    always_comb
    begin
        rdata_next = `PSFB_ZERO16;
        if (hit(ADDR, `PSFB_OFF_RUN_STATE))
        begin
            rdata_next = st_reg.run_state;
        end
        else if (hit(ADDR, `PSFB_OFF_BUSY_FLAGS))
        begin
            rdata_next = busy_word;
        end
        else if (hit(ADDR, `PSFB_OFF_DIAG_CODE))
        begin
            rdata_next = st_reg.diag_code;
        end
        else if (hit(ADDR, `PSFB_OFF_IO_BOARD_ERR))
        begin
            rdata_next = st_reg.io_board_err;
        end
        else if (hit(ADDR, `PSFB_OFF_CASSETTE_ERR))
        begin
            rdata_next = st_reg.cassette_err;
        end
        else if (hit(ADDR, `PSFB_OFF_COMM_ERR))
        begin
            rdata_next = st_reg.comm_err;
        end
        else if (hit(ADDR, `PSFB_OFF_EXP_VERIFY))
        begin
            rdata_next = st_reg.exp_verify;
        end
        else if (hit(ADDR, `PSFB_OFF_VARIANT))
        begin
            rdata_next = {14'h0000, OUTPUT_VARIANT};
        end
        else if (hit(ADDR, `PSFB_OFF_INT_STATUS))
        begin
            rdata_next = {11'h000, int_status_reg};
        end
        else if (hit(ADDR, `PSFB_OFF_INT_MASK))
        begin
            rdata_next = {11'h000, int_mask_reg};
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            RDATA <= `PSFB_ZERO16;
        end
        else if (RD)
        begin
            RDATA <= rdata_next;
        end
        else
        begin
            RDATA <= `PSFB_ZERO16;
        end
    end
endmodule
`default_nettype wire

// file: psfb_flag_bank_asserts.sv
/* Port checker for psfb_flag_bank.
   Bound to the bank; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none

module psfb_flag_bank_asserts
    import psfb_pkg::*;
(
    // clock
    input wire logic CLOCK,
    input wire logic NRST,
    // bus
    input wire logic [4:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    input wire logic IRQ,
    // sources
    input wire logic [15:0] UNIT_RUN_MODE,
    input wire psfb_activity_t CHANNEL_ACTIVE,
    input wire psfb_variant_t OUTPUT_VARIANT,
    input wire logic DIAG_ERR_STB,
    input wire logic [15:0] DIAG_ERR_CODE
);
    logic [15:0] busy_w;
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);
    always_comb
    begin
        busy_w = {CHANNEL_ACTIVE.pls_active, CHANNEL_ACTIVE.ctr_active};
        if (OUTPUT_VARIANT != PSFB_RELAY_OUTPUT)
            busy_w[11:8] = 4'h0;
        if (OUTPUT_VARIANT != PSFB_TRANSISTOR_OUTPUT)
            busy_w[15:14] = 2'h0;
    end
    property p_idle;
        !RD |=> RDATA == 16'h0000;
    endproperty
    a_idle: assert property (p_idle)
        else $error("read data without a read");
    property p_hole;
        RD && !(ADDR inside {[5'h00:5'h02], 5'h04, 5'h08, 5'h0b, 5'h0c, [5'h10:5'h12]})
            |=> RDATA == 16'h0000;
    endproperty
    a_hole: assert property (p_hole)
        else $error("unused address not zero");
    property p_run;
        RD && ADDR == 5'h00 |=> RDATA == $past(UNIT_RUN_MODE, 2);
    endproperty
    a_run: assert property (p_run)
        else $error("unit mode word wrong");
    property p_busy;
        RD && ADDR == 5'h01 |=> RDATA == $past(busy_w, 2);
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy word wrong");
    property p_diag;
        DIAG_ERR_STB ##1 !DIAG_ERR_STB ##1 (RD && ADDR == 5'h02 && !DIAG_ERR_STB)
            |=> RDATA == $past(DIAG_ERR_CODE, 3);
    endproperty
    a_diag: assert property (p_diag)
        else $error("diagnostic code wrong");
    property p_cass;
        RD && ADDR == 5'h08 |=> (RDATA & 16'hfff9) == 16'h0000;
    endproperty
    a_cass: assert property (p_cass)
        else $error("cassette map bit outside 1 and 2");
    property p_exp;
        RD && ADDR == 5'h0c |=> RDATA[15:8] == 8'h00;
    endproperty
    a_exp: assert property (p_exp)
        else $error("verify map bit above 7");
    property p_irq_off;
        WR && ADDR == 5'h12 && WDATA[4:0] == 5'h00 |=> !IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq with empty mask");
    c_diag: cover property (DIAG_ERR_STB);
    c_irq: cover property ($rose(IRQ));
    c_busy: cover property (RD && ADDR == 5'h01 && OUTPUT_VARIANT == PSFB_TRANSISTOR_OUTPUT);
endmodule

bind psfb_flag_bank psfb_flag_bank_asserts u_chk (.*);
`default_nettype wire

// file: psfb_pkg.sv
/*
 * Types shared by the status flag bank modules.
 * Assumes psfb_consts.svh is on the include path.
 */
`include "psfb_consts.svh"

package psfb_pkg;
    typedef struct packed {
        logic [15:0] run_state;
        logic [15:0] diag_code;
        logic [15:0] io_board_err;
        logic [15:0] cassette_err;
        logic [15:0] comm_err;
        logic [15:0] exp_verify;
    } psfb_status_t;

    typedef struct packed {
        logic [`PSFB_CTR_CH-1:0] ctr_active;
        logic [`PSFB_PLS_CH-1:0] pls_active;
    } psfb_activity_t;

    typedef enum logic [1:0] {
        PSFB_RELAY_OUTPUT = 2'b01,
        PSFB_TRANSISTOR_OUTPUT = 2'b10
    } psfb_variant_t;
endpackage

// file: tb_top.sv
/* Self-checking bench for psfb_flag_bank.
   Assumes the package and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import psfb_pkg::*;
;
    logic clk;
    logic nrst;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic [15:0] run;
    psfb_activity_t act;
    psfb_variant_t var_sel;
    logic dstb;
    logic [15:0] dcode;
    logic [15:0] io_set;
    logic [15:0] cas_set;
    logic c_use;
    logic c_stb;
    logic [15:0] c_data;
    logic [7:0] exp_in;
    logic irq;
    logic [31:0] rnd;
    logic [31:0] stim;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;

    psfb_flag_bank dut (
        .CLOCK(clk),
        .NRST(nrst),
        .ADDR(addr),
        .WDATA(wdata),
        .WR(wr),
        .RD(rd),
        .RDATA(rdata),
        .UNIT_RUN_MODE(run),
        .CHANNEL_ACTIVE(act),
        .OUTPUT_VARIANT(var_sel),
        .DIAG_ERR_STB(dstb),
        .DIAG_ERR_CODE(dcode),
        .IO_BOARD_ERR_SET(io_set),
        .CASSETTE_ERR_SET(cas_set),
        .COMM_PORT_IN_USE(c_use),
        .COMM_ERR_STB(c_stb),
        .COMM_ERR_CONTENT(c_data),
        .EXP_PRESENT(exp_in),
        .IRQ(irq)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // activity vector is {ctr, pls}; the word puts pls on top
    function automatic logic [15:0] busy_exp(input logic [15:0] a, input logic t);
        return {a[3:0], a[15:4]} & (t ? 16'hf0ff : 16'h3fff);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] e);
        tests_run++;
        if (got !== e)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    initial
    begin
        {nrst, addr, wdata, wr, rd, run, act, dstb, dcode} = '0;
        {io_set, cas_set, c_use, c_stb, c_data, exp_in} = '0;
        var_sel = PSFB_RELAY_OUTPUT;
        rnd = 32'he0dea57d;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 32; i++)
            if (i < 16 || i > 18)
            begin
                wr_reg(i[4:0], 16'hffff);
                rd_chk(i[4:0], 16'h0000);
            end
        $display("test 1 done");
        // both variants, all-ones first for each, then the seeded sequence
        for (int j = 0; j < 16; j++)
        begin
            stim = (j < 2) ? 32'hffffffff : rnd;
            if (j >= 2)
                rnd = lfsr(rnd);
            @(posedge clk);
            run <= stim[31:16];
            act <= stim[15:0];
            var_sel <= j[0] ? PSFB_TRANSISTOR_OUTPUT : PSFB_RELAY_OUTPUT;
            rd_chk(5'h00, stim[31:16]);
            rd_chk(5'h01, busy_exp(stim[15:0], j[0]));
            rd_chk(5'h10, j[0] ? 16'h0002 : 16'h0001);
        end
        @(posedge clk);
        act <= '0;
        rd_chk(5'h01, 16'h0000);
        $display("test 2 done");
        wr_reg(5'h12, 16'h001f);
        rd_chk(5'h12, 16'h001f);
        @(posedge clk);
        dstb <= 1'b1;
        dcode <= rnd[15:0];
        @(posedge clk);
        dstb <= 1'b0;
        #1 chk({15'h0000, irq}, 16'h0001);
        rd_chk(5'h02, rnd[15:0]);
        rd_chk(5'h11, 16'h0001);
        wr_reg(5'h11, 16'h0001);
        #1 chk({15'h0000, irq}, 16'h0000);
        // clear and event in one cycle: the event must survive
        @(posedge clk);
        wr <= 1'b1;
        addr <= 5'h11;
        wdata <= 16'h0001;
        dstb <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        dstb <= 1'b0;
        rd_chk(5'h11, 16'h0001);
        wr_reg(5'h11, 16'h0001);
        #1 chk({15'h0000, irq}, 16'h0000);
        wr_reg(5'h12, 16'h0000);
        $display("test 3 done");
        @(posedge clk);
        io_set <= 16'h0005;
        cas_set <= 16'hffff;
        c_stb <= 1'b1;
        c_data <= 16'h00a5;
        exp_in <= 8'h08;
        @(posedge clk);
        io_set <= 16'h0100;
        cas_set <= '0;
        c_stb <= 1'b0;
        @(posedge clk);
        io_set <= '0;
        rd_chk(5'h04, 16'h0105);
        rd_chk(5'h08, 16'h0006);
        rd_chk(5'h0b, 16'h0000);
        @(posedge clk);
        c_use <= 1'b1;
        c_stb <= 1'b1;
        c_data <= 16'h005a;
        exp_in <= 8'h00;
        @(posedge clk);
        c_stb <= 1'b0;
        rd_chk(5'h0b, 16'h005a);
        rd_chk(5'h0c, 16'h0008);
        #1 chk({15'h0000, irq}, 16'h0000);
        rd_chk(5'h11, 16'h001e);
        wr_reg(5'h12, 16'h0010);
        #1 chk({15'h0000, irq}, 16'h0001);
        wr_reg(5'h11, 16'h001e);
        #1 chk({15'h0000, irq}, 16'h0000);
        $display("test 4 done");
        // mid-run reset: maps clear and the new installation is the baseline
        @(posedge clk);
        nrst <= 1'b0;
        exp_in <= 8'h08;
        @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        rd_chk(5'h04, 16'h0000);
        rd_chk(5'h0b, 16'h0000);
        rd_chk(5'h0c, 16'h0000);
        rd_chk(5'h11, 16'h0000);
        $display("test 5 done");
        report_and_stop();
    end
endmodule
`default_nettype wire
